// *** design/crd_top.sv ***
/*
 Processor section glue: processor clock generation with rate select,
 internal state enable, board reset from power-up, manual switch and the
 bus initialize line, and the demultiplexed 16-bit address bus.
 Assumes all pin inputs are synchronous to CLK_IN.
*/
`default_nettype none
module crd_top
	import crd_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYC
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	// reset sources and clock rate select
	input wire logic MANUAL_RST_N_IN,
	input wire logic INIT_N_IN,
	input wire logic FAST_SEL_IN,
	// processor bus
	input wire crd_pkg::crd_cpu_t CPU_IN,
	input wire logic [BYTE_W-1:0] MUXED_LOW_ADDR_DATA_IN,
	// processor clock and states
	output logic CPU_CLK_OUT,
	output logic STATE_EN_OUT,
	// address and data
	output logic [ADDR_W-1:0] ADDR_OUT,
	output logic [BYTE_W-1:0] DATA_RD_OUT,
	output logic [BYTE_W-1:0] MUXED_LOW_ADDR_DATA_OUT,
	output logic MUXED_LOW_ADDR_DATA_OE_N_OUT,
	// reset distribution
	output logic INIT_N_OUT,
	output logic INIT_N_OE_N_OUT,
	output crd_pkg::crd_unit_rst_t UNIT_RST_OUT,
	output crd_pkg::crd_src_t RST_SRC_OUT
);
	logic rst_s1_r;
	logic rst_n;
	logic [DIV_W-1:0] div_r;
	logic [DIV_W-1:0] div_lim;
	logic half_en;
	logic state_odd_r;
	logic [INIT_W-1:0] init_cnt_r;
	logic pwr_busy;
	logic manual_rst;
	logic bus_rst;
	logic init_own_r;
	logic board_rst_r;
	logic [BYTE_W-1:0] low_addr;
	logic capture;
	logic phase_data_r;
	crd_src_t src_nxt;

	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	assign div_lim = FAST_SEL_IN ? FAST_HALF : SLOW_HALF;
	// >= so a switch from slow to fast never waits for the counter to wrap
	assign half_en = (div_r >= div_lim);

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
			CPU_CLK_OUT <= 1'b0;
		end else if (half_en) begin
			div_r <= '0;
			CPU_CLK_OUT <= !CPU_CLK_OUT;
		end else begin
			div_r <= div_r + DIV_W'(1);
		end
	end

	// one state per two input periods: pulse on every second falling edge
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			STATE_EN_OUT <= 1'b0;
			state_odd_r <= 1'b0;
		end else begin
			if (half_en && CPU_CLK_OUT) begin
				state_odd_r <= !state_odd_r;
			end
			STATE_EN_OUT <= half_en && CPU_CLK_OUT && state_odd_r;
		end
	end

	// power-up stretch: the count starts at zero after reset release
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_r <= '0;
		end else if (pwr_busy) begin
			init_cnt_r <= init_cnt_r + INIT_W'(1);
		end
	end

	assign pwr_busy = (init_cnt_r < INIT_W'(INIT_CYCLES));
	assign manual_rst = !MANUAL_RST_N_IN;
	// only an external low counts, never our own drive echoed back
	assign bus_rst = !INIT_N_IN && !init_own_r;

	always_comb begin
		if (pwr_busy) begin
			src_nxt = CRD_SRC_POWER;
		end else if (manual_rst) begin
			src_nxt = CRD_SRC_MANUAL;
		end else if (bus_rst) begin
			src_nxt = CRD_SRC_BUS;
		end else begin
			src_nxt = CRD_SRC_NONE;
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			board_rst_r <= 1'b1;
			init_own_r <= 1'b1;
			RST_SRC_OUT <= CRD_SRC_POWER;
			INIT_N_OUT <= 1'b0;
			INIT_N_OE_N_OUT <= 1'b0;
			UNIT_RST_OUT <= '1;
		end else begin
			board_rst_r <= src_nxt != CRD_SRC_NONE;
			init_own_r <= pwr_busy || manual_rst;
			RST_SRC_OUT <= src_nxt;
			INIT_N_OUT <= 1'b0;
			INIT_N_OE_N_OUT <= !(pwr_busy || manual_rst);
			UNIT_RST_OUT <= {4{board_rst_r}};
		end
	end

	crd_addr_latch u_latch (
		.clk_in(CLK_IN),
		.rst_n_in(rst_n),
		.strobe_in(CPU_IN.addr_strobe),
		.muxed_low_addr_data_in(MUXED_LOW_ADDR_DATA_IN),
		.low_addr_out(low_addr),
		.capture_out(capture)
	);

	// data phase opens at the capture and lasts until the next strobe or a board reset
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			phase_data_r <= 1'b0;
		end else if (CPU_IN.addr_strobe || board_rst_r) begin
			phase_data_r <= 1'b0;
		end else if (capture) begin
			phase_data_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ADDR_OUT <= ADDR_ZERO;
			DATA_RD_OUT <= BYTE_ZERO;
			MUXED_LOW_ADDR_DATA_OUT <= BYTE_ZERO;
			MUXED_LOW_ADDR_DATA_OE_N_OUT <= 1'b1;
		end else begin
			ADDR_OUT <= {CPU_IN.high_addr, low_addr};
			if (phase_data_r && !CPU_IN.read_n) begin
				DATA_RD_OUT <= MUXED_LOW_ADDR_DATA_IN;
			end
			MUXED_LOW_ADDR_DATA_OUT <= CPU_IN.muxed_drive;
			// drive toward the pins only for a write in the data phase
			MUXED_LOW_ADDR_DATA_OE_N_OUT <= !(phase_data_r &&
				!CPU_IN.write_n && !CPU_IN.muxed_oe_n && !board_rst_r);
		end
	end

	sequence s_cap;
		capture ##1 1'b1;
	endsequence
	property p_addr;
		@(posedge CLK_IN) disable iff (!rst_n)
		s_cap |-> ADDR_OUT ==
			{$past(CPU_IN.high_addr), $past(low_addr)};
	endproperty
	a_addr: assert property (p_addr) else $error("address join");

	property p_state;
		@(posedge CLK_IN) disable iff (!rst_n)
		STATE_EN_OUT |-> $fell(CPU_CLK_OUT) ##1 !STATE_EN_OUT [*8];
	endproperty
	a_state: assert property (p_state) else $error("state pulse");

	property p_units;
		@(posedge CLK_IN) disable iff (!rst_n)
		board_rst_r |=> UNIT_RST_OUT == '1;
	endproperty
	a_units: assert property (p_units) else $error("unit reset");

	property p_manual;
		@(posedge CLK_IN) disable iff (!rst_n)
		manual_rst |=> (!INIT_N_OE_N_OUT && board_rst_r) ##1
			UNIT_RST_OUT == '1;
	endproperty
	a_manual: assert property (p_manual) else $error("manual");

	property p_power;
		@(posedge CLK_IN) disable iff (!rst_n)
		pwr_busy |=> board_rst_r && !INIT_N_OE_N_OUT;
	endproperty
	a_power: assert property (p_power) else $error("power-up");

	property p_bus;
		@(posedge CLK_IN) disable iff (!rst_n)
		bus_rst |=> board_rst_r;
	endproperty
	a_bus: assert property (p_bus) else $error("bus init");

	property p_pins_idle;
		@(posedge CLK_IN) disable iff (!rst_n)
		board_rst_r |=> MUXED_LOW_ADDR_DATA_OE_N_OUT;
	endproperty
	a_pins_idle: assert property (p_pins_idle) else $error("drive");

	property p_rd_only_data;
		@(posedge CLK_IN) disable iff (!rst_n)
		!phase_data_r |=> $stable(DATA_RD_OUT);
	endproperty
	a_rd_only_data: assert property (p_rd_only_data) else $error("rd");
endmodule : crd_top
`default_nettype wire

// *** design/crd_pkg.sv ***
/*
 Package for the processor reset and address demultiplexer block: widths,
 timing counts, reset-source encoding and the carrier structs.
 Assumes a single 125 MHz system clock.
*/
`default_nettype none
package crd_pkg;
	localparam int CLK_PERIOD_PS = 8000;
	// processor input clock choices, in kHz
	localparam int FAST_RATE_KHZ = 9690;
	localparam int SLOW_RATE_KHZ = 4840;
	localparam int CLK_RATE_KHZ = 125000;
	// half period of the generated processor clock, in system cycles
	localparam int FAST_HALF_CYC = CLK_RATE_KHZ / (2 * FAST_RATE_KHZ);
	localparam int SLOW_HALF_CYC = CLK_RATE_KHZ / (2 * SLOW_RATE_KHZ);
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] FAST_HALF = DIV_W'(FAST_HALF_CYC - 1);
	localparam logic [DIV_W-1:0] SLOW_HALF = DIV_W'(SLOW_HALF_CYC - 1);
	// least width of the power-up board reset, in ms
	localparam int INIT_WIDTH_MS = 10;
	localparam int INIT_CYC = INIT_WIDTH_MS * (CLK_RATE_KHZ);
	localparam int INIT_W = 21;
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

	typedef enum logic [1:0] {
		CRD_SRC_NONE,
		CRD_SRC_POWER,
		CRD_SRC_MANUAL,
		CRD_SRC_BUS
	} crd_src_t;

	// processor-side bus signals entering the block
	typedef struct packed {
		logic addr_strobe;
		logic read_n;
		logic write_n;
		logic [BYTE_W-1:0] high_addr;
		logic [BYTE_W-1:0] muxed_drive;
		logic muxed_oe_n;
	} crd_cpu_t;

	// unit resets fanned out over the board
	typedef struct packed {
		logic cpu_rst;
		logic pio_input_dir;
		logic sio_idle;
		logic busctl_rst;
	} crd_unit_rst_t;
endpackage : crd_pkg
`default_nettype wire

// *** design/crd_addr_latch.sv ***
/*
 Low address latch: captures the low address byte from the shared pins on
 the trailing edge of the address strobe and holds it until the next one.
 Assumes strobe and pins are synchronous to the system clock.
*/
`default_nettype none
module crd_addr_latch
	import crd_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// capture side
	input wire logic strobe_in,
	input wire logic [BYTE_W-1:0] muxed_low_addr_data_in,
	// latched byte
	output logic [BYTE_W-1:0] low_addr_out,
	output logic capture_out
);
	logic strobe_r;
	logic [BYTE_W-1:0] data_r;
	logic fall;

	// pins are sampled one cycle late so the byte seen at the strobe's
	// last high cycle is the one kept
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strobe_r <= 1'b0;
			data_r <= BYTE_ZERO;
		end else begin
			strobe_r <= strobe_in;
			data_r <= muxed_low_addr_data_in;
		end
	end

	assign fall = strobe_r && !strobe_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_addr_out <= BYTE_ZERO;
			capture_out <= 1'b0;
		end else begin
			capture_out <= fall;
			if (fall) begin
				low_addr_out <= data_r;
			end
		end
	end

	property p_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		!fall |=> $stable(low_addr_out);
	endproperty
	a_hold: assert property (p_hold) else $error("latch changed");

	property p_trailing;
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(strobe_in) |=> !capture_out;
	endproperty
	a_trailing: assert property (p_trailing) else $error("lead edge");

	property p_capture;
		@(posedge clk_in) disable iff (!rst_n_in)
		fall |=> capture_out && low_addr_out == $past(data_r);
	endproperty
	a_capture: assert property (p_capture) else $error("capture");
endmodule : crd_addr_latch
`default_nettype wire

// *** tb/crd_mem_model.sv ***
/*
 Memory-side model of the shared low address/data pins: resolves the wire
 level from the block, the processor and a memory that answers reads.
 Assumes the bench drives the processor signals and samples on CLK_IN.
*/
`default_nettype none
module crd_mem_model
	import crd_pkg::*;
(
	// clock
	input wire logic clk_in,
	// pin parties
	input wire crd_pkg::crd_cpu_t cpu_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic oe_n_in,
	input wire logic [BYTE_W-1:0] drv_in,
	// resolved level
	output logic [BYTE_W-1:0] pins_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [BYTE_W-1:0] last_r = 8'h00;
	always_ff @(posedge clk_in) begin
		last_r <= pins_out;
	end
	// a released bus toggles so a stale byte can never look valid
	always_comb begin
		if (!oe_n_in)
			pins_out = drv_in;
		else if (!cpu_in.muxed_oe_n)
			pins_out = cpu_in.muxed_drive;
		else if (!cpu_in.read_n)
			pins_out = addr_in[7:0] ^ addr_in[15:8] ^ 8'h5A;
		else
			pins_out = ~last_r;
	end
endmodule : crd_mem_model
`default_nettype wire

// *** tb/crd_top_tb.sv ***
/*
 Self-checking bench for the reset and address demultiplexer block.
 Assumes the memory model on the shared pins and a pulled-up init line.
*/
`default_nettype none
module crd_top_tb
	import crd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INIT_N = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic man_n = 1'b1;
	logic ext_n = 1'b1;
	logic fast = 1'b1;
	crd_cpu_t cpu = '{1'b0, 1'b1, 1'b1, 8'h00, 8'h00, 1'b1};
	logic [BYTE_W-1:0] pins, mdo, rd;
	logic cclk, sen, moe_n, ino, ioe_n;
	wire logic init_lvl;
	logic [ADDR_W-1:0] addr;
	crd_unit_rst_t urst;
	crd_src_t src;
	int n_errors = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'hA5EEAAC5;
	// open drain with pull-up: low if either party pulls
	assign init_lvl = ext_n & (ioe_n | ino);
	crd_top #(.INIT_CYCLES(INIT_N)) crd_top_i (.CLK_IN(clk),
		.RSTN_IN(rst_n), .MANUAL_RST_N_IN(man_n), .INIT_N_IN(init_lvl),
		.FAST_SEL_IN(fast), .CPU_IN(cpu), .MUXED_LOW_ADDR_DATA_IN(pins),
		.CPU_CLK_OUT(cclk), .STATE_EN_OUT(sen), .ADDR_OUT(addr),
		.DATA_RD_OUT(rd), .MUXED_LOW_ADDR_DATA_OUT(mdo),
		.MUXED_LOW_ADDR_DATA_OE_N_OUT(moe_n), .INIT_N_OUT(ino),
		.INIT_N_OE_N_OUT(ioe_n), .UNIT_RST_OUT(urst), .RST_SRC_OUT(src));
	crd_mem_model crd_mem_model_i (.clk_in(clk), .cpu_in(cpu),
		.addr_in(addr), .oe_n_in(moe_n), .drv_in(mdo), .pins_out(pins));
	initial begin
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] memb(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : memb
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic finish_test;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wait_rel;
		for (int i = 0; i < 200 && urst !== 4'h0; i++)
			step;
		chk("unit_rst_clear", 16'h0, 16'(urst));
		chk("rst_src", 16'(CRD_SRC_NONE), 16'(src));
		if (urst !== 4'h0)
			finish_test;
	endtask : wait_rel
	task automatic clk_chk(input int n);
		int c, p;
		logic q;
		for (int k = 0; k < 3; k++) begin
			c = 0;
			// pulses are counted over the last two full clock periods
			if (k < 2)
				p = 0;
			do begin
				q = cclk;
				step;
				c++;
				p += int'(sen === 1'b1);
			end while (!(cclk === 1'b1 && q === 1'b0) && c < 64);
		end
		chk("cpu_clk_period", 16'(n), 16'(c));
		chk("state_pulses", 16'h1, 16'(p));
	endtask : clk_chk
	task automatic bus_cyc(input logic [15:0] a);
		logic [7:0] d;
		d = 8'(rnd());
		cpu.high_addr = a[15:8];
		cpu.muxed_drive = ~a[7:0];
		cpu.muxed_oe_n = 1'b0;
		cpu.addr_strobe = 1'b1;
		step;
		// only the byte just before the fall may be taken
		cpu.muxed_drive = a[7:0];
		step;
		cpu.addr_strobe = 1'b0;
		cpu.muxed_drive = d;
		repeat (3) step;
		chk("addr", a, addr);
		cpu.muxed_oe_n = 1'b1;
		cpu.read_n = 1'b0;
		repeat (3) step;
		chk("read_data", {8'h00, memb(a)}, {8'h00, rd});
		cpu.read_n = 1'b1;
		cpu.write_n = 1'b0;
		cpu.muxed_oe_n = 1'b0;
		repeat (2) step;
		chk("pins_oe_n", 16'h0, {15'h0, moe_n});
		chk("write_data", {8'h00, d}, {8'h00, mdo});
		cpu.write_n = 1'b1;
		cpu.muxed_oe_n = 1'b1;
		repeat (2) step;
		chk("pins_oe_n", 16'h1, {15'h0, moe_n});
		chk("addr_hold", a, addr);
	endtask : bus_cyc
	task automatic rst_chk(input crd_src_t s, input logic own);
		repeat (3) step;
		chk("unit_rst", 16'hF, 16'(urst));
		chk("init_oe_n", {15'h0, ~own}, {15'h0, ioe_n});
		chk("rst_src", 16'(s), 16'(src));
		chk("pins_oe_n", 16'h1, {15'h0, moe_n});
	endtask : rst_chk
	initial begin
		repeat (3) step;
		chk("unit_rst", 16'hF, 16'(urst));
		chk("init_oe_n", 16'h0, {15'h0, ioe_n});
		chk("rst_src", 16'(CRD_SRC_POWER), 16'(src));
		rst_n = 1'b1;
		wait_rel;
		chk("init_oe_n", 16'h1, {15'h0, ioe_n});
		clk_chk(2 * FAST_HALF_CYC);
		fast = 1'b0;
		clk_chk(2 * SLOW_HALF_CYC);
		fast = 1'b1;
		bus_cyc(16'hFFFF);
		bus_cyc(16'h0000);
		repeat (16) bus_cyc(16'(rnd()));
		man_n = 1'b0;
		rst_chk(CRD_SRC_MANUAL, 1'b1);
		man_n = 1'b1;
		wait_rel;
		ext_n = 1'b0;
		rst_chk(CRD_SRC_BUS, 1'b0);
		ext_n = 1'b1;
		wait_rel;
		bus_cyc(16'(rnd()));
		// second power-up in mid-run
		rst_n = 1'b0;
		step;
		chk("unit_rst", 16'hF, 16'(urst));
		chk("rst_src", 16'(CRD_SRC_POWER), 16'(src));
		rst_n = 1'b1;
		wait_rel;
		bus_cyc(16'(rnd()));
		finish_test;
	end
endmodule : crd_top_tb
`default_nettype wire
